// File: inc/lblc_pkg.sv
// Constants, types and carriers shared by the LED behaviour/link control.
package lblc_pkg;

  localparam int NCH = 8;
  localparam int BEH_W = 2;
  localparam int PCT_FULL = 100;

  localparam logic [7:0] ADDR_LTRAN = 8'h77;
  localparam logic [7:0] ADDR_MIRROR = 8'h79;
  localparam logic [7:0] ADDR_BEH_LO = 8'h81;
  localparam logic [7:0] ADDR_BEH_HI = 8'h82;

  localparam logic [7:0] RST_LTRAN = 8'h00;
  localparam logic [7:0] RST_MIRROR = 8'h00;
  localparam logic [7:0] RST_BEH_LO = 8'h00;
  localparam logic [7:0] RST_BEH_HI = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    BEH_DIRECT = 2'h0,
    BEH_PULSE1 = 2'h1,
    BEH_PULSE2 = 2'h2,
    BEH_BREATHE = 2'h3
  } lblc_beh_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_TAIL = 3'h4
  } lblc_st_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lblc_reg_req_s;

endpackage

// File: design/lblc_led_ctrl.sv
// LED behaviour select, link transition and duty mirror control, 8 channels.
module lblc_led_ctrl #(
  parameter int DUTY_W = 7
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire lblc_pkg::lblc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] output_polarity,
  input wire logic polarity_wr,
  input wire logic [7:0] link_en,
  input wire logic [7:0] host_drive_bit,
  input wire logic [7:0] touch,
  input wire logic invert_link_transition,
  input wire logic block_polarity_mirror,
  input wire logic [7:0] pulse_done,
  input wire logic [DUTY_W-1:0] duty_min,
  input wire logic [DUTY_W-1:0] duty_max,
  output logic [7:0] actuated,
  output logic [7:0] pin_level,
  output logic [7:0] idle_level,
  output logic [15:0] behavior_select,
  output logic [7:0] duty_mirror_enable,
  output logic [lblc_pkg::NCH-1:0][DUTY_W-1:0] eff_min,
  output logic [lblc_pkg::NCH-1:0][DUTY_W-1:0] eff_max
);

  localparam int NCH = lblc_pkg::NCH;
  localparam logic [DUTY_W-1:0] FULL = DUTY_W'(lblc_pkg::PCT_FULL);

  function automatic lblc_pkg::lblc_beh_e beh_of(input logic [15:0] v,
                                                  input int ch);
    beh_of = lblc_pkg::lblc_beh_e'(v[2*ch +: lblc_pkg::BEH_W]);
  endfunction

  function automatic logic [DUTY_W-1:0] mirror_duty(
    input logic [DUTY_W-1:0] val, input logic en);
    mirror_duty = en ? FULL - val : val;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [7:0] ltran_q, ltran_d;
  logic [7:0] mirror_q, mirror_d;
  logic [15:0] beh_q, beh_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    ltran_d = ltran_q;
    mirror_d = mirror_q;
    beh_d = beh_q;
    rdata_d = rdata_q;
    if (reg_req.wr) begin
      case (reg_req.addr)
        lblc_pkg::ADDR_LTRAN: ltran_d = reg_req.wdata;
        lblc_pkg::ADDR_MIRROR: mirror_d = reg_req.wdata;
        lblc_pkg::ADDR_BEH_LO: beh_d[7:0] = reg_req.wdata;
        lblc_pkg::ADDR_BEH_HI: beh_d[15:8] = reg_req.wdata;
        default: ;
      endcase
    end
    // The polarity update is the hardware event, so it wins over a write.
    if (polarity_wr && !block_polarity_mirror) begin
      mirror_d = output_polarity;
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        lblc_pkg::ADDR_LTRAN: rdata_d = ltran_q;
        lblc_pkg::ADDR_MIRROR: rdata_d = mirror_q;
        lblc_pkg::ADDR_BEH_LO: rdata_d = beh_q[7:0];
        lblc_pkg::ADDR_BEH_HI: rdata_d = beh_q[15:8];
        default: rdata_d = lblc_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ltran_q <= lblc_pkg::RST_LTRAN;
      mirror_q <= lblc_pkg::RST_MIRROR;
      beh_q <= {lblc_pkg::RST_BEH_HI, lblc_pkg::RST_BEH_LO};
      rdata_q <= lblc_pkg::RDATA_UNMAPPED;
    end else begin
      ltran_q <= ltran_d;
      mirror_q <= mirror_d;
      beh_q <= beh_d;
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command source selection and link transition handling.

  logic [7:0] link_prev_q, link_prev_d;
  logic [7:0] hold_q, hold_d;
  logic [7:0] req_q, req_d;
  logic [7:0] req_prev_q, req_prev_d;
  logic [7:0] link_rise;
  logic [7:0] hold_now;
  logic [7:0] rise;
  logic [7:0] fall;

  always_comb begin
    link_rise = link_en & ~link_prev_q;
    // Linking with drive set and no touch may freeze the present state.
    hold_now = link_en & (hold_q |
               (link_rise & ltran_q & host_drive_bit & ~touch));
    hold_d = hold_now;
    link_prev_d = link_en;
    for (int i = 0; i < NCH; i++) begin
      if (!link_en[i]) begin
        req_d[i] = host_drive_bit[i];
      end else if (hold_now[i]) begin
        req_d[i] = invert_link_transition ? ~touch[i] : 1'b1;
      end else begin
        req_d[i] = touch[i];
      end
    end
    req_prev_d = req_q;
    rise = req_q & ~req_prev_q;
    fall = ~req_q & req_prev_q;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_prev_q <= 8'h00;
      hold_q <= 8'h00;
      req_q <= 8'h00;
      req_prev_q <= 8'h00;
    end else begin
      link_prev_q <= link_prev_d;
      hold_q <= hold_d;
      req_q <= req_d;
      req_prev_q <= req_prev_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-channel behaviour state machines.

  lblc_pkg::lblc_st_e st_q [NCH];
  lblc_pkg::lblc_st_e st_d [NCH];
  logic [7:0] act_d;
  logic [7:0] pin_d;
  logic [7:0] freeze;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      st_d[i] = st_q[i];
      case (st_q[i])
        lblc_pkg::ST_IDLE: begin
          if (rise[i]) begin
            st_d[i] = lblc_pkg::ST_RUN;
          end
        end
        lblc_pkg::ST_RUN: begin
          // The select is read live, so a change applies at once.
          case (beh_of(beh_q, i))
            lblc_pkg::BEH_PULSE1: begin
              // The request is not looked at until the pulses end.
              if (pulse_done[i]) begin
                st_d[i] = lblc_pkg::ST_IDLE;
              end
            end
            lblc_pkg::BEH_PULSE2: begin
              if (fall[i]) begin
                st_d[i] = lblc_pkg::ST_TAIL;
              end
            end
            default: begin
              if (fall[i]) begin
                st_d[i] = lblc_pkg::ST_IDLE;
              end
            end
          endcase
        end
        lblc_pkg::ST_TAIL: begin
          if (rise[i]) begin
            st_d[i] = lblc_pkg::ST_RUN;
          end else if (pulse_done[i]) begin
            st_d[i] = lblc_pkg::ST_IDLE;
          end
        end
        default: st_d[i] = lblc_pkg::ST_IDLE;
      endcase
      act_d[i] = (st_d[i] != lblc_pkg::ST_IDLE);
      pin_d[i] = ~(act_d[i] ^ output_polarity[i]);
      // Unlinked channels with any behaviour but direct keep the duty seen at actuation.
      freeze[i] = actuated[i] & ~link_en[i] &
                  (beh_of(beh_q, i) != lblc_pkg::BEH_DIRECT);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NCH; i++) begin
        st_q[i] <= lblc_pkg::ST_IDLE;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        st_q[i] <= st_d[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic [lblc_pkg::NCH-1:0][DUTY_W-1:0] emin_d;
  logic [lblc_pkg::NCH-1:0][DUTY_W-1:0] emax_d;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      emin_d[i] = eff_min[i];
      emax_d[i] = eff_max[i];
      if (!freeze[i]) begin
        emin_d[i] = mirror_duty(duty_min, mirror_q[i]);
        emax_d[i] = mirror_duty(duty_max, mirror_q[i]);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      actuated <= 8'h00;
      pin_level <= 8'hff;
      idle_level <= 8'hff;
      behavior_select <= 16'h0000;
      duty_mirror_enable <= 8'h00;
      eff_min <= '0;
      eff_max <= '0;
    end else begin
      actuated <= act_d;
      pin_level <= pin_d;
      idle_level <= ~output_polarity;
      behavior_select <= beh_d;
      duty_mirror_enable <= mirror_d;
      eff_min <= emin_d;
      eff_max <= emax_d;
    end
  end

  assign reg_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_linked_ignores_drive;
    @(posedge mclk) disable iff (!arst_n)
      ((req_q ^ $past(touch)) & $past(link_en & ~hold_now)) == 8'h00;
  endproperty
  a_linked_ignores_drive: assert property (p_linked_ignores_drive)
    else $error("linked request did not follow the touch input");

  property p_unlinked_drive;
    @(posedge mclk) disable iff (!arst_n)
      ((req_q ^ $past(host_drive_bit)) & ~$past(link_en)) == 8'h00;
  endproperty
  a_unlinked_drive: assert property (p_unlinked_drive)
    else $error("unlinked request did not follow the drive bit");

  property p_link_release;
    @(posedge mclk) disable iff (!arst_n)
      (req_q & $past(link_rise & ~ltran_q & ~touch)) == 8'h00;
  endproperty
  a_link_release: assert property (p_link_release)
    else $error("link with clear select did not release");

  property p_hold_inverted;
    @(posedge mclk) disable iff (!arst_n)
      invert_link_transition |=>
        ((req_q ^ ~$past(touch)) & $past(hold_now)) == 8'h00;
  endproperty
  a_hold_inverted: assert property (p_hold_inverted)
    else $error("held channel did not invert the touch");

  property p_hold_kept;
    @(posedge mclk) disable iff (!arst_n)
      !invert_link_transition |=> (~req_q & $past(hold_now)) == 8'h00;
  endproperty
  a_hold_kept: assert property (p_hold_kept)
    else $error("held channel lost its state");

  property p_polarity_mirror;
    @(posedge mclk) disable iff (!arst_n)
      (polarity_wr && !block_polarity_mirror) ##1 1'b1 |->
        duty_mirror_enable == $past(output_polarity);
  endproperty
  a_polarity_mirror: assert property (p_polarity_mirror)
    else $error("mirror bits did not copy the polarity");

  property p_beh_readback;
    @(posedge mclk) disable iff (!arst_n)
      (reg_req.rd && reg_req.addr == lblc_pkg::ADDR_BEH_HI) |=>
        reg_rdata == $past(beh_q[15:8]);
  endproperty
  a_beh_readback: assert property (p_beh_readback)
    else $error("high behaviour register read back wrong");

  property p_pin_polarity;
    @(posedge mclk) disable iff (!arst_n)
      pin_level == ~(actuated ^ $past(output_polarity));
  endproperty
  a_pin_polarity: assert property (p_pin_polarity)
    else $error("pin level does not match polarity and actuation");

  property p_start_trigger;
    @(posedge mclk) disable iff (!arst_n)
      ($past(rise & ~actuated) & ~actuated) == 8'h00;
  endproperty
  a_start_trigger: assert property (p_start_trigger)
    else $error("start trigger did not actuate the channel");

  property p_pulse1_runs;
    @(posedge mclk) disable iff (!arst_n)
      (st_q[0] == lblc_pkg::ST_RUN && !pulse_done[0] &&
       beh_of(beh_q, 0) == lblc_pkg::BEH_PULSE1 &&
       beh_of(beh_d, 0) == lblc_pkg::BEH_PULSE1) |=> actuated[0];
  endproperty
  a_pulse1_runs: assert property (p_pulse1_runs)
    else $error("pulse-1 ended before its sequence finished");

endmodule // lblc_led_ctrl

// File: testbench/lblc_far_model.sv
// Far-side model: touch results and pulse sequence completion per LED.
module lblc_far_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] actuated,
  input wire logic [7:0] touch_cmd,
  input wire logic [7:0] dly,
  output logic [7:0] touch,
  output logic [7:0] pulse_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q [8];
  ////////////////////////////////////////////////////////////////////////////
  // The sequence generator only runs while the channel is actuated.
  assign touch = touch_cmd;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        cnt_q[i] <= 8'h00;
      end
      pulse_done <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!actuated[i]) begin
          cnt_q[i] <= 8'h00;
          pulse_done[i] <= 1'b0;
        end else begin
          pulse_done[i] <= (cnt_q[i] == dly);
          cnt_q[i] <= (cnt_q[i] == dly) ? 8'h00 : cnt_q[i] + 8'h01;
        end
      end
    end
  end
endmodule // lblc_far_model

// File: testbench/lblc_led_ctrl_tb.sv
// Self-checking bench for the LED behaviour and link control.
`define CMP(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module lblc_led_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int k; logic [15:0] e;} lblc_note_s;
  lblc_note_s exp_q[$];
  lblc_note_s nt;
  string nm[8] = '{"rdata", "actuated", "pin_level", "idle_level",
    "behavior_select", "mirror", "eff_min0", "eff_max0"};
  int n_mismatch = 0;
  int checks_done = 0;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic look = 1'b0;
  lblc_pkg::lblc_reg_req_s req = '0;
  logic [7:0] pol = 8'h00, link = 8'h00, drv = 8'h00, tcmd = 8'h00;
  logic [7:0] dly = 8'h0a, rdata, act, pin, idle, mir, done, tch, r;
  logic pwr = 1'b0, inv = 1'b0, blk = 1'b0;
  logic [6:0] dmin = 7'h00, dmax = 7'h00, dmax2;
  logic [15:0] beh;
  logic [7:0][6:0] emin, emax;
  logic [7:0] addrs [4] = '{8'h77, 8'h79, 8'h81, 8'h82};
  always #2.5 mclk = ~mclk;
  lblc_led_ctrl lblc_led_ctrl_i (.mclk(mclk), .arst_n(arst_n),
    .reg_req(req), .reg_rdata(rdata), .output_polarity(pol),
    .polarity_wr(pwr), .link_en(link), .host_drive_bit(drv), .touch(tch),
    .invert_link_transition(inv), .block_polarity_mirror(blk),
    .pulse_done(done), .duty_min(dmin), .duty_max(dmax), .actuated(act),
    .pin_level(pin), .idle_level(idle), .behavior_select(beh),
    .duty_mirror_enable(mir), .eff_min(emin), .eff_max(emax));
  lblc_far_model lblc_far_model_i (.mclk(mclk), .arst_n(arst_n),
    .actuated(act), .touch_cmd(tcmd), .dly(dly), .touch(tch),
    .pulse_done(done));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] seen(int k);
    case (k)
      0: return {8'h00, rdata};
      1: return {8'h00, act};
      2: return {8'h00, pin};
      3: return {8'h00, idle};
      4: return beh;
      5: return {8'h00, mir};
      6: return {9'h000, emin[0]};
      default: return {9'h000, emax[0]};
    endcase
  endfunction
  always @(negedge mclk) begin
    if (look && exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      `CMP(nm[nt.k], nt.e, seen(nt.k))
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic step(int n);
    repeat (n) tick();
  endtask
  task automatic chk(int k, logic [15:0] e);
    exp_q.push_back('{k, e});
    look = 1'b1;
    tick();
    look = 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick();
    req.wr = 1'b0;
    // Let an edge pass so back-to-back writes see the strobe low for one cycle between them.
    tick();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    tick();
    req.rd = 1'b0;
    chk(0, {8'h00, e});
  endtask
  task automatic finish_test();
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(8000 * 5);
    n_mismatch++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(14));
    repeat (20) @(posedge mclk);
    #1 arst_n = 1'b1;
    tick();
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(8'h80, 8'h00);
    chk(3, 16'h00ff);
    foreach (addrs[i]) begin
      r = 8'($urandom);
      wr(addrs[i], r);
      rd(addrs[i], r);
    end
    wr(8'h81, 8'he4);
    wr(8'h82, 8'h1b);
    chk(4, 16'h1be4);
    foreach (addrs[i]) wr(addrs[i], 8'h00);
    drv = 8'h01;
    step(1);
    chk(1, 16'h0000);
    chk(1, 16'h0001);
    chk(2, 16'h00fe);
    link = 8'h02;
    drv = 8'h03;
    step(2);
    chk(1, 16'h0001);
    tcmd = 8'h02;
    step(2);
    chk(1, 16'h0003);
    drv = 8'h00;
    link = 8'h00;
    tcmd = 8'h00;
    step(3);
    for (int c = 0; c < 3; c++) begin
      wr(8'h77, c > 0 ? 8'h04 : 8'h00);
      inv = (c == 2);
      drv = 8'h04;
      step(2);
      link = 8'h04;
      step(2);
      chk(1, c > 0 ? 16'h0004 : 16'h0000);
      tcmd = 8'h04;
      step(2);
      chk(1, c == 2 ? 16'h0000 : 16'h0004);
      link = 8'h00;
      drv = 8'h00;
      tcmd = 8'h00;
      step(3);
      chk(1, 16'h0000);
    end
    dmin = 7'($urandom_range(100));
    dmax = 7'($urandom_range(100));
    pol = 8'hff;
    pwr = 1'b1;
    tick();
    pwr = 1'b0;
    step(3);
    chk(5, 16'h00ff);
    chk(6, 16'(100 - int'(dmin)));
    chk(7, 16'(100 - int'(dmax)));
    chk(2, 16'h0000);
    chk(3, 16'h0000);
    blk = 1'b1;
    pol = 8'h00;
    pwr = 1'b1;
    tick();
    pwr = 1'b0;
    step(3);
    chk(5, 16'h00ff);
    blk = 1'b0;
    wr(8'h79, 8'h00);
    step(2);
    chk(6, {9'h000, dmin});
    inv = 1'b1;
    wr(8'h81, 8'h03);
    drv = 8'h01;
    step(3);
    dmax2 = (dmax == 7'h64) ? 7'h00 : dmax + 7'h01;
    dmax = dmax2;
    step(3);
    chk(7, {9'h000, dmax2 == 7'h00 ? 7'h64 : dmax2 - 7'h01});
    drv = 8'h00;
    step(2);
    drv = 8'h01;
    step(3);
    chk(7, {9'h000, dmax2});
    wr(8'h81, 8'h01);
    drv = 8'h00;
    step(2);
    chk(1, 16'h0001);
    step(30);
    chk(1, 16'h0000);
    drv = 8'h01;
    step(2);
    chk(1, 16'h0001);
    drv = 8'h00;
    tick();
    drv = 8'h01;
    step(2);
    chk(1, 16'h0001);
    step(20);
    chk(1, 16'h0000);
    drv = 8'h00;
    wr(8'h81, 8'h02);
    drv = 8'h01;
    step(2);
    chk(1, 16'h0001);
    drv = 8'h00;
    step(2);
    chk(1, 16'h0001);
    step(20);
    chk(1, 16'h0000);
    finish_test();
  end
endmodule // lblc_led_ctrl_tb
